/* File: hw/rt_mode_cmd_record_writer.sv */
// receive mode command record writer with axi4-lite control registers
`timescale 1ns/1ps

// Summary of operation
// R1: codes 0-15 store info and tag only
// R2: info at pointer, tag at pointer plus one
// R3: codes 16-31 store a received data word at pointer plus two
// R4: data word also offered to mode action when info bit 10 is clear: no error, and not a broadcast in broadcast mode
// R5: codes 16,18,19 answer in form unless disabled
// R6: codes 0-15 answer in form unless disabled
// R7: record written only after message completion
// R8: bit 14 flags invalid data word
// R9: bit 13 flags gap error in gap mode
// R10: bit 13 flags broadcast in other mode
// R11: bit 12 flags missing or extra word
// R12: bit 11 flags wrong sync on data
// R13: bit 10 set when bits 11-14 any
// R14: bit 9 flags busy response
// R15: bit 8 flags illegalization table bit
// R16: bit 5 gives bus a or b
// R17: bits 4-0 hold mode code
// R18: record start from descriptor data pointer
// R19: bits 15, 7, 6 written zero
module rt_mode_cmd_record_writer (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // completed message from the protocol engine
    input  wire logic                    msg_done,
    input  wire rt_mode_rec_pkg::msg_t   msg,
    output logic                         msg_ready,
    // answer decisions toward the protocol engine, for the current msg
    output logic                         respond_in_form,
    output logic                         respond_busy,
    // mode data handed to the mode action logic
    output logic                         mode_data_valid,
    output logic [4:0]                   mode_data_code,
    output logic [15:0]                  mode_data_word,
    // shared ram write port
    output rt_mode_rec_pkg::ram_wr_t     ram_wr,
    // axi4-lite slave
    input  wire logic [7:0]              s_awaddr,
    input  wire logic                    s_awvalid,
    output logic                         s_awready,
    input  wire logic [31:0]             s_wdata,
    input  wire logic [3:0]              s_wstrb,
    input  wire logic                    s_wvalid,
    output logic                         s_wready,
    output logic [1:0]                   s_bresp,
    output logic                         s_bvalid,
    input  wire logic                    s_bready,
    input  wire logic [7:0]              s_araddr,
    input  wire logic                    s_arvalid,
    output logic                         s_arready,
    output logic [31:0]                  s_rdata,
    output logic [1:0]                   s_rresp,
    output logic                         s_rvalid,
    input  wire logic                    s_rready
);

    // ******************************************
    // state
    // ******************************************
    typedef struct packed {
        rt_mode_rec_pkg::wr_state_t wr;       // record write sequencer
        rt_mode_rec_pkg::msg_t      msg;      // captured message
        logic [15:0]                info;     // built information word
        rt_mode_rec_pkg::ram_wr_t   ram;      // ram write output
        logic                       mdv;      // mode data pulse
        logic [31:0]                cfg;      // configuration register
        logic [15:0]                last_inf; // last information word
        logic [15:0]                count;    // records written
        logic                       aw_got;   // write address held
        logic                       w_got;    // write data held
        logic [7:0]                 awaddr;
        logic [31:0]                wdata;
        logic [3:0]                 wstrb;
        logic                       bvalid;
        logic [1:0]                 bresp;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
    } state_t;

    state_t s_q;  // registered state
    state_t s_d;  // next state

    // ******************************************
    // helper functions
    // ******************************************
    // mode codes 16..31 carry a data word
    function automatic logic has_data(input logic [4:0] mc);
        return mc >= rt_mode_rec_pkg::MC_FIRST_DATA;
    endfunction : has_data

    // undefined receive mode codes: all without data, and 16, 18, 19
    function automatic logic is_undef(input logic [4:0] mc);
        return !has_data(mc) || mc == rt_mode_rec_pkg::MC_UNDEF_A ||
               mc == rt_mode_rec_pkg::MC_UNDEF_B || mc == rt_mode_rec_pkg::MC_UNDEF_C;
    endfunction : is_undef

    // strobe-merged register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // build the information word from a completed message
    function automatic logic [15:0] build_info(input rt_mode_rec_pkg::msg_t m,
                                               input logic [31:0] cfg);
        logic [15:0] w;
        logic        wc_err;
        w = 16'h0000;                                              // R19
        wc_err = (has_data(m.mode_code) != m.data_seen) || m.extra_word;
        w[rt_mode_rec_pkg::BIT_INVALID_WORD] = m.word_invalid;     // R8
        w[rt_mode_rec_pkg::BIT_GAP_OR_BROADCAST_FLAG] = cfg[rt_mode_rec_pkg::CFG_BCAST] ?
                                            m.broadcast        // R10
                                          : m.gap_error;       // R9
        w[rt_mode_rec_pkg::BIT_WORD_COUNT] = wc_err;               // R11
        w[rt_mode_rec_pkg::BIT_SYNC_TYPE] = m.sync_wrong;          // R12
        w[rt_mode_rec_pkg::BIT_MSG_ERROR] = m.word_invalid | w[13] | wc_err
                                          | m.sync_wrong;          // R13
        w[rt_mode_rec_pkg::BIT_BUSY_RESP] = cfg[rt_mode_rec_pkg::CFG_BUSY]
                                          | m.per_cmd_busy;        // R14
        w[rt_mode_rec_pkg::BIT_ILLEGAL] = m.illegal_bit;           // R15
        w[rt_mode_rec_pkg::BIT_BUS_SELECT] = m.on_bus_b;           // R16
        w[4:0] = m.mode_code;                                      // R17
        return w;
    endfunction : build_info

    // ******************************************
    // combinational outputs
    // ******************************************
    // one message accepted at a time; the engine holds msg_done until taken
    assign msg_ready = (s_q.wr == rt_mode_rec_pkg::WR_IDLE);
    // undefined codes answered in form only with table bit and control clear
    assign respond_in_form = !is_undef(msg.mode_code) ||
                             (!msg.illegal_bit &&
                              !s_q.cfg[rt_mode_rec_pkg::CFG_UNDEFINED_MODE_INVALID_CTL]);  // R5 R6 R15
    assign respond_busy    = s_q.cfg[rt_mode_rec_pkg::CFG_BUSY] | msg.per_cmd_busy;  // R14
    assign mode_data_valid = s_q.mdv;                                // R4
    assign mode_data_code  = s_q.msg.mode_code;
    assign mode_data_word  = s_q.msg.data_word;
    assign ram_wr          = s_q.ram;
    assign s_awready       = !s_q.aw_got && !s_q.bvalid;
    assign s_wready        = !s_q.w_got && !s_q.bvalid;
    assign s_bvalid        = s_q.bvalid;
    assign s_bresp         = s_q.bresp;
    assign s_arready       = !s_q.rvalid;
    assign s_rvalid        = s_q.rvalid;
    assign s_rdata         = s_q.rdata;
    assign s_rresp         = s_q.rresp;

    // ******************************************
    // next-state logic
    // ******************************************
    always_comb begin
        s_d = s_q;
        s_d.ram.valid = 1'b0;
        s_d.mdv = 1'b0;
        // record write sequencer, started only once the message is done
        unique case (s_q.wr)
            rt_mode_rec_pkg::WR_IDLE: begin
                if (msg_done) begin                                   // R7
                    s_d.msg  = msg;
                    s_d.info = build_info(msg, s_q.cfg);
                    s_d.wr   = rt_mode_rec_pkg::WR_INFO;
                end
            end
            rt_mode_rec_pkg::WR_INFO: begin
                s_d.ram.valid = 1'b1;
                s_d.ram.addr  = s_q.msg.data_ptr + rt_mode_rec_pkg::OFS_INFO;  // R2 R18
                s_d.ram.data  = s_q.info;
                s_d.last_inf  = s_q.info;
                s_d.wr        = rt_mode_rec_pkg::WR_TAG;
            end
            rt_mode_rec_pkg::WR_TAG: begin
                s_d.ram.valid = 1'b1;
                s_d.ram.addr  = s_q.msg.data_ptr + rt_mode_rec_pkg::OFS_TAG;   // R2
                s_d.ram.data  = s_q.msg.time_tag;
                s_d.count     = s_q.count + 16'h0001;
                // short record for codes without data
                if (has_data(s_q.msg.mode_code) && s_q.msg.data_seen) begin  // R1 R3
                    s_d.wr = rt_mode_rec_pkg::WR_DATA;
                end else begin
                    s_d.wr = rt_mode_rec_pkg::WR_IDLE;
                end
            end
            rt_mode_rec_pkg::WR_DATA: begin
                s_d.ram.valid = 1'b1;
                s_d.ram.addr  = s_q.msg.data_ptr + rt_mode_rec_pkg::OFS_DATA;  // R3
                s_d.ram.data  = s_q.msg.data_word;
                // only a clean data word is handed to the mode action
                s_d.mdv = !s_q.info[rt_mode_rec_pkg::BIT_MSG_ERROR];            // R4
                s_d.wr  = rt_mode_rec_pkg::WR_IDLE;
            end
        endcase

        // axi write: address and data taken in either order
        if (s_awvalid && s_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_wdata;
            s_d.wstrb = s_wstrb;
        end
        if (s_q.aw_got && s_q.w_got) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            if (s_q.awaddr == rt_mode_rec_pkg::REG_CONFIG) begin
                s_d.cfg   = merge(s_q.cfg, s_q.wdata, s_q.wstrb) & 32'h0000_0007;
                s_d.bresp = rt_mode_rec_pkg::RESP_OKAY;
            end else if (s_q.awaddr == rt_mode_rec_pkg::REG_STATUS ||
                         s_q.awaddr == rt_mode_rec_pkg::REG_LASTINF) begin
                s_d.bresp = rt_mode_rec_pkg::RESP_OKAY;   // read-only, write ignored
            end else begin
                s_d.bresp = rt_mode_rec_pkg::RESP_SLVERR;
            end
        end
        if (s_q.bvalid && s_bready) begin
            s_d.bvalid = 1'b0;
        end

        // axi read
        if (s_arvalid && s_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = rt_mode_rec_pkg::RESP_OKAY;
            unique case (s_araddr)
                rt_mode_rec_pkg::REG_CONFIG:  s_d.rdata = s_q.cfg;
                rt_mode_rec_pkg::REG_STATUS:  s_d.rdata = {14'h0000, s_q.wr, s_q.count};
                rt_mode_rec_pkg::REG_LASTINF: s_d.rdata = {16'h0000, s_q.last_inf};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = rt_mode_rec_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_q.rvalid && s_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    // ******************************************
    // state register, synchronous active-low reset
    // ******************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q     <= '0;
            s_q.wr  <= rt_mode_rec_pkg::WR_IDLE;
            s_q.cfg <= rt_mode_rec_pkg::CFG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ******************************************
    // assertions
    // ******************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_info_at_ptr: assert property (  // R2
        (s_q.wr == rt_mode_rec_pkg::WR_INFO) |=> ram_wr.valid &&
            ram_wr.addr == $past(s_q.msg.data_ptr))
        else $error("information word not at data pointer");

    a_tag_follows: assert property (  // R2
        (s_q.wr == rt_mode_rec_pkg::WR_INFO) |=> ##1 ram_wr.valid &&
            ram_wr.addr == $past(ram_wr.addr) + 16'h0001)
        else $error("time tag not at pointer plus one");

    a_short_record: assert property (  // R1
        (s_q.wr == rt_mode_rec_pkg::WR_TAG && !has_data(s_q.msg.mode_code))
            |=> ##1 !ram_wr.valid)
        else $error("extra word written for code without data");

    a_data_at_two: assert property (  // R3
        (s_q.wr == rt_mode_rec_pkg::WR_DATA) |=> ram_wr.addr ==
            $past(s_q.msg.data_ptr) + 16'h0002)
        else $error("data word not at pointer plus two");

    a_write_after_done: assert property (  // R7
        $rose(ram_wr.valid) |-> $past(s_q.wr, 1) != rt_mode_rec_pkg::WR_IDLE)
        else $error("record written before message completion");

    a_message_error_flag_summary: assert property (  // R13
        s_q.wr != rt_mode_rec_pkg::WR_IDLE |-> s_q.info[10] == (|s_q.info[14:11]))
        else $error("message error not summary of bits 11 to 14");

    a_unused_zero: assert property (  // R19
        s_q.wr != rt_mode_rec_pkg::WR_IDLE |-> s_q.info[15] == 1'b0 &&
            s_q.info[7:6] == 2'b00)
        else $error("unused information bits not zero");

    a_mode_field: assert property (  // R17
        s_q.wr == rt_mode_rec_pkg::WR_INFO |-> s_q.info[4:0] == s_q.msg.mode_code &&
            s_q.info[5] == s_q.msg.on_bus_b)
        else $error("mode code or bus field wrong");

    a_undef_refused: assert property (  // R5
        (s_q.cfg[rt_mode_rec_pkg::CFG_UNDEFINED_MODE_INVALID_CTL] && is_undef(msg.mode_code)) |-> !respond_in_form)
        else $error("undefined code answered in form while disabled");

    c_short_record: cover property (
        s_q.wr == rt_mode_rec_pkg::WR_TAG ##1 s_q.wr == rt_mode_rec_pkg::WR_IDLE);
    c_data_record: cover property (s_q.wr == rt_mode_rec_pkg::WR_DATA);
    c_axi_write: cover property (s_bvalid && s_bready);
    c_error_info: cover property (s_q.wr == rt_mode_rec_pkg::WR_INFO && s_q.info[10]);

endmodule : rt_mode_cmd_record_writer

/* File: hw/rt_mode_rec_pkg.sv */
// package for the receive mode command record writer: layouts, offsets, enums
package rt_mode_rec_pkg;

    // ******************************************
    // information word bit positions
    // ******************************************
    localparam int BIT_INVALID_WORD = 14;  // invalid data word
    localparam int BIT_GAP_OR_BROADCAST_FLAG    = 13;  // gap error or broadcast
    localparam int BIT_WORD_COUNT   = 12;  // missing or extra word
    localparam int BIT_SYNC_TYPE    = 11;  // command sync on data word
    localparam int BIT_MSG_ERROR    = 10;  // any of bits 11..14
    localparam int BIT_BUSY_RESP    = 9;   // answered busy
    localparam int BIT_ILLEGAL      = 8;   // illegalization bit set
    localparam int BIT_BUS_SELECT   = 5;   // 0 bus a, 1 bus b

    // ******************************************
    // record layout, word offsets from the data pointer
    // ******************************************
    localparam logic [15:0] OFS_INFO = 16'h0000;  // information word
    localparam logic [15:0] OFS_TAG  = 16'h0001;  // time-tag word
    localparam logic [15:0] OFS_DATA = 16'h0002;  // mode data word

    // ******************************************
    // mode codes
    // ******************************************
    localparam logic [4:0] MC_FIRST_DATA = 5'h10;  // first code with data word
    localparam logic [4:0] MC_UNDEF_A    = 5'h10;  // undefined receive code
    localparam logic [4:0] MC_UNDEF_B    = 5'h12;  // undefined receive code
    localparam logic [4:0] MC_UNDEF_C    = 5'h13;  // undefined receive code

    // ******************************************
    // axi4-lite register map (byte addresses)
    // ******************************************
    localparam logic [7:0]  REG_CONFIG  = 8'h00;  // control bits
    localparam logic [7:0]  REG_STATUS  = 8'h04;  // block state, count
    localparam logic [7:0]  REG_LASTINF = 8'h08;  // last information word
    localparam int          CFG_UNDEFINED_MODE_INVALID_CTL  = 0;      // undefined mode invalid
    localparam int          CFG_BCAST   = 1;      // 1: bit 13 flags broadcast
    localparam int          CFG_BUSY    = 2;      // global busy status
    localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // one completed receive mode message as seen by the protocol engine
    typedef struct packed {
        logic [4:0]  mode_code;    // from the command word
        logic [15:0] data_ptr;     // descriptor data pointer
        logic        per_cmd_busy; // descriptor control word busy bit
        logic        illegal_bit;  // illegalization table bit for command
        logic        on_bus_b;     // bus the message arrived on
        logic        broadcast;    // broadcast message
        logic        data_seen;    // a data word was received
        logic        extra_word;   // more words than expected
        logic        word_invalid; // manchester or parity error
        logic        sync_wrong;   // command/status sync on data word
        logic        gap_error;    // gap before or activity after data
        logic [15:0] data_word;    // received mode data word
        logic [15:0] time_tag;     // time tag at completion
    } msg_t;

    // one ram write
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [15:0] data;
    } ram_wr_t;

    typedef enum logic [1:0] { WR_IDLE, WR_INFO, WR_TAG, WR_DATA } wr_state_t;

endpackage : rt_mode_rec_pkg

/* File: tb/mode_msg_source.sv */
// behavioural protocol engine that hands completed receive mode messages to the writer
`timescale 1ns/1ps

module mode_msg_source (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  send,
    input  wire rt_mode_rec_pkg::msg_t send_msg,
    input  wire logic                  msg_ready,
    output logic                       msg_done,
    output rt_mode_rec_pkg::msg_t      msg,
    output logic                       idle
);
    // ******************************************
    // message hand-off
    // ******************************************
    // a message stands until the writer takes it; between messages the
    // fields toggle every cycle so a stale message never looks valid
    always @(posedge aclk) begin
        if (!aresetn) begin
            msg_done <= 1'b0;
            msg      <= '0;
        end else if (msg_done && msg_ready) begin
            msg_done <= 1'b0;           // taken at this edge
            msg      <= ~msg;
        end else if (send && !msg_done) begin
            msg_done <= 1'b1;
            msg      <= send_msg;       // illegal bit only as the table holds it
        end else if (!msg_done) begin
            msg      <= ~msg;           // idle pattern
        end
    end

    assign idle = !msg_done;

endmodule : mode_msg_source

/* File: tb/rt_mode_cmd_record_writer_tb.sv */
// self-checking bench for the receive mode command record writer
`timescale 1ns/1ps

module rt_mode_cmd_record_writer_tb;
    // ******************************************
    // signals
    // ******************************************
    logic                    aclk, aresetn, send, msg_done, msg_ready, idle;
    rt_mode_rec_pkg::msg_t   send_msg, msg;
    logic                    respond_in_form, respond_busy, mode_data_valid;
    logic [4:0]              mode_data_code;
    logic [15:0]             mode_data_word;
    rt_mode_rec_pkg::ram_wr_t ram_wr;
    logic [7:0]              s_awaddr, s_araddr;
    logic [31:0]             s_wdata, s_rdata;
    logic [1:0]              s_bresp, s_rresp;
    logic                    s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic                    s_arvalid, s_arready, s_rvalid, s_rready;
    int                      miscompares, checked, nrec;
    logic [31:0]             seed, wq[$];   // captured ram writes {addr, data}
    logic [20:0]             mq[$];         // captured mode data {code, word}

    rt_mode_cmd_record_writer rt_mode_cmd_record_writer_i (
        .aclk(aclk), .aresetn(aresetn), .msg_done(msg_done), .msg(msg),
        .msg_ready(msg_ready), .respond_in_form(respond_in_form),
        .respond_busy(respond_busy), .mode_data_valid(mode_data_valid),
        .mode_data_code(mode_data_code), .mode_data_word(mode_data_word),
        .ram_wr(ram_wr), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

    mode_msg_source mode_msg_source_i (
        .aclk(aclk), .aresetn(aresetn), .send(send), .send_msg(send_msg),
        .msg_ready(msg_ready), .msg_done(msg_done), .msg(msg), .idle(idle));

    // ******************************************
    // clock, monitor, hang guard
    // ******************************************
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // registered outputs are sampled before this edge's updates land
    always @(posedge aclk) begin
        if (aresetn === 1'b1 && ram_wr.valid === 1'b1) wq.push_back({ram_wr.addr, ram_wr.data});
        if (aresetn === 1'b1 && mode_data_valid === 1'b1) mq.push_back({mode_data_code, mode_data_word});
    end

    initial begin
        repeat (100000) @(posedge aclk);
        miscompares++;
        finish_test();
    end

    // ******************************************
    // helpers
    // ******************************************
    task automatic finish_test();
        $display("compares %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask : chk

    // bounded wait on a sampled condition; a run-out ends the test
    task automatic tick_or_die(int n);
        if (n > 50) begin
            $display("[ERR] handshake expected done seen stuck");
            miscompares++;
            finish_test();
        end
        @(posedge aclk);
    endtask : tick_or_die

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic axi_write(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
        int n;
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        n = 0;
        // each channel is released at the edge it is taken; bready is held high from the start
        do begin
            tick_or_die(n++);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end while (!(s_bvalid === 1'b1 && !s_awvalid && !s_wvalid));
        r = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        s_rready  <= 1'b1;
        n = 0;
        do begin
            tick_or_die(n++);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end while (!(s_rvalid === 1'b1 && !s_arvalid));
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_read

    // ******************************************
    // expectations
    // ******************************************
    // message error sums bits 11 to 14, whatever bit 13 means in this mode
    function automatic logic [15:0] exp_info(rt_mode_rec_pkg::msg_t m, logic [2:0] cfg);
        logic wc, b13, me;
        wc  = (m.data_seen != m.mode_code[4]) | m.extra_word;
        b13 = cfg[rt_mode_rec_pkg::CFG_BCAST] ? m.broadcast : m.gap_error;
        me  = m.word_invalid | wc | m.sync_wrong | b13;
        return {1'b0, m.word_invalid, b13, wc, m.sync_wrong, me,
                cfg[rt_mode_rec_pkg::CFG_BUSY] | m.per_cmd_busy, m.illegal_bit,
                2'b00, m.on_bus_b, m.mode_code};
    endfunction : exp_info

    // one message: configure, present, check answers, record and registers
    task automatic run_msg(rt_mode_rec_pkg::msg_t m, logic [2:0] cfg);
        logic [1:0]  r;
        logic [31:0] d;
        logic [15:0] inf;
        logic        und, dat;
        int          n;
        axi_write(rt_mode_rec_pkg::REG_CONFIG, {29'h0, cfg}, r);
        chk("cfg write resp", 32'(rt_mode_rec_pkg::RESP_OKAY), 32'(r));
        inf = exp_info(m, cfg);
        und = !m.mode_code[4] || m.mode_code inside {5'h10, 5'h12, 5'h13};
        dat = m.mode_code[4] && m.data_seen;
        wq.delete();
        mq.delete();
        send     <= 1'b1;
        send_msg <= m;
        @(posedge aclk);
        send <= 1'b0;
        @(negedge aclk);
        chk("in form", 32'(!(und && (m.illegal_bit || cfg[0]))), 32'(respond_in_form));
        chk("busy", 32'(cfg[2] | m.per_cmd_busy), 32'(respond_busy));
        chk("early writes", 0, wq.size());
        n = 0;
        while (msg_done === 1'b1) tick_or_die(n++);
        while (msg_ready !== 1'b1) tick_or_die(n++);
        @(posedge aclk);
        nrec++;
        chk("record words", dat ? 3 : 2, wq.size());
        chk("info word", {m.data_ptr, inf}, wq[0]);
        chk("tag word", {m.data_ptr + 16'h0001, m.time_tag}, wq[1]);
        if (dat) chk("data word", {m.data_ptr + 16'h0002, m.data_word}, wq[2]);
        chk("mode data count", (dat && !inf[10]) ? 1 : 0, mq.size());
        if (mq.size() == 1) chk("mode data", {11'h0, m.mode_code, m.data_word}, 32'(mq[0]));
        axi_read(rt_mode_rec_pkg::REG_LASTINF, d, r);
        chk("last info", 32'(inf), 32'(d[15:0]));
        axi_read(rt_mode_rec_pkg::REG_STATUS, d, r);
        chk("record count", 32'(nrec[15:0]), 32'(d[15:0]));
    endtask : run_msg

    // ******************************************
    // main sequence
    // ******************************************
    initial begin
        logic [31:0] d, e;
        logic [1:0]  r;
        logic [4:0]  corner[8];
        seed = 32'h542abe26;
        corner = '{5'h00, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h1f, 5'h01};
        {aresetn, send, send_msg, s_awaddr, s_araddr, s_wdata} = '0;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {miscompares, checked, nrec} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // register map: reset value, read-only place, unmapped place
        axi_read(rt_mode_rec_pkg::REG_CONFIG, d, r);
        chk("cfg reset", rt_mode_rec_pkg::CFG_RESET, d);
        axi_write(rt_mode_rec_pkg::REG_STATUS, 32'hffff_ffff, r);
        chk("status write resp", 32'(rt_mode_rec_pkg::RESP_OKAY), 32'(r));
        axi_write(8'h40, 32'h0000_0007, r);
        chk("unmapped write", 32'(rt_mode_rec_pkg::RESP_SLVERR), 32'(r));
        axi_read(8'h40, d, r);
        chk("unmapped read", 32'(rt_mode_rec_pkg::RESP_SLVERR), 32'(r));
        axi_write(rt_mode_rec_pkg::REG_CONFIG, 32'hffff_ffff, r);
        axi_read(rt_mode_rec_pkg::REG_CONFIG, d, r);
        chk("cfg bits", 32'h0000_0007, d);
        // corner codes, clean words, every config and illegal bit combination
        for (int c = 0; c < 8; c++) begin
            for (int k = 0; k < 16; k++) begin
                d = rnd();
                run_msg({corner[c], d[15:0], 1'b0, k[3], k[0], k[1], corner[c][4],
                         4'h0, d[31:16], 16'hfff0 ^ d[15:0]}, k[2:0]);
            end
        end
        // random codes, flags, pointers and configurations
        for (int i = 0; i < 200; i++) begin
            d = rnd();
            e = rnd();
            run_msg({d[4:0], e[15:0], d[13:5], e[31:16], d[31:16]}, d[16:14]);
        end
        finish_test();
    end

endmodule : rt_mode_cmd_record_writer_tb
